//--- src/pld_pkg.sv
// Package of constants and carrier types for the PLL divider and lock detect block.
// Assumes a single 10 MHz clock domain and no register bus.
package pld_pkg;
	localparam int CLK_MHZ = 10;
	localparam int NUM_OUT = 5;
	localparam logic [4:0] DIV_RESET = 5'h00;
	localparam logic [4:0] OUT_DIV_RESET = 5'h00;
	localparam logic [3:0] LOCK_CNT_RESET = 4'h0;
	localparam int LOCK_STEP = 16;
	localparam logic [3:0] CP_CODE_LAST = 4'hD;
	localparam logic [2:0] RES_CODE_LAST = 3'h5;
	localparam logic [3:0] CP_RESET = 4'h1;
	localparam logic [2:0] RES_RESET = 3'h0;
	localparam int SETTLE_US = 25;
	localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

	typedef enum logic {
		PLD_MODE_PHASE,
		PLD_MODE_FREQ
	} pld_mode_t;

	typedef struct packed {
		logic [4:0] in_div;
		logic [4:0] fb_div;
		logic [4:0] out_div_0;
		logic [4:0] out_div_1;
		logic [4:0] out_div_2;
		logic [4:0] out_div_3;
		logic [4:0] out_div_4;
		logic [2:0] fb_sel;
		logic bypass;
		pld_mode_t mode;
		logic [3:0] lock_cnt;
		logic [3:0] cp_code;
		logic [2:0] res_code;
	} pld_cfg_t;
endpackage : pld_pkg

//--- src/pld_divider.sv
// Programmable clock-enable divider with synchronous resynchronisation.
// Assumes it is stepped by a one-cycle tick from the same clock domain.
`timescale 1ns/10ps
module pld_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic resync,
	input wire logic [6:0] ratio,
	output logic out_r,
	output logic pulse_r
);
	logic [6:0] cnt_r;
	logic [6:0] half;

	// Half of the ratio sets the high phase of the output.
	assign half = {1'b0, ratio[6:1]};

	// Count ticks, wrap at the ratio and restart on resync.
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 7'h00;
			out_r <= 1'b0;
			pulse_r <= 1'b0;
		end else if (ce) begin
			pulse_r <= 1'b0;
			if (resync) begin
				cnt_r <= 7'h00;
				out_r <= 1'b0;
			end else if (tick) begin
				if (cnt_r + 7'h01 >= ratio) begin
					cnt_r <= 7'h00;
					pulse_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 7'h01;
				end
				out_r <= (cnt_r + 7'h01 < ratio) && (cnt_r + 7'h01 >= half);
			end
		end
	end
endmodule : pld_divider

//--- src/pld_core.sv
// Digital control of the clock synthesizer: dividers, lock detection and loop codes.
// Assumes the reference and the oscillator feedback arrive as pins on the 10 MHz clock,
// where the oscillator stands in as a sampled tick source for the output dividers.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////
module pld_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic ref_pin,
	input wire logic vco_pin,
	input wire pld_pkg::pld_cfg_t cfg,
	output logic lock_n_r,
	output logic freq_lock_r,
	output logic [4:0] clk_out_r,
	output logic [3:0] cp_code_r,
	output logic [2:0] res_code_r,
	output logic [4:0] vco_base_r
);
	logic [2:0] ref_sync_r;
	logic [2:0] vco_sync_r;
	logic ref_rise;
	logic vco_rise;
	logic [4:0] in_cnt_r;
	logic [4:0] fb_cnt_r;
	logic in_pulse_r;
	logic fb_pulse_r;
	logic [6:0] ratio [pld_pkg::NUM_OUT];
	logic [4:0] dout;
	logic [4:0] dpulse;
	logic fb_tick;
	logic phase_lock_r;
	logic [8:0] freq_cnt_r;
	logic [8:0] freq_target;
	logic [7:0] ref_idle_r;
	logic ref_lost;
	logic resync_r;
	logic locked;
	logic [1:0] fb_in_window_r;
	logic ref_rise_hold_r;
	logic vco_rise_hold_r;
	logic [24:0] out_codes;

	//////////////////////////////////////////////////////////////////////////////////////
	// Pin inputs pass three flops; a rising edge counts once stages two and three agree.
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_sync_r <= 3'h0;
			vco_sync_r <= 3'h0;
		end else if (ce) begin
			ref_sync_r <= {ref_sync_r[1:0], ref_pin};
			vco_sync_r <= {vco_sync_r[1:0], vco_pin};
		end
	end
	assign ref_rise = ref_sync_r[1] & ref_sync_r[2] & ~ref_rise_hold_r;
	assign vco_rise = vco_sync_r[1] & vco_sync_r[2] & ~vco_rise_hold_r;

	// Remember the agreed level so each edge is counted once.
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_rise_hold_r <= 1'b0;
			vco_rise_hold_r <= 1'b0;
		end else if (ce) begin
			if (ref_sync_r[1] == ref_sync_r[2]) begin
				ref_rise_hold_r <= ref_sync_r[2];
			end
			if (vco_sync_r[1] == vco_sync_r[2]) begin
				vco_rise_hold_r <= vco_sync_r[2];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Input prescaler; a code of zero stands for a ratio of 32.
	always_ff @(posedge clk) begin
		if (rst) begin
			in_cnt_r <= pld_pkg::DIV_RESET;
			in_pulse_r <= 1'b0;
		end else if (ce) begin
			in_pulse_r <= 1'b0;
			if (ref_rise) begin
				if (in_cnt_r == cfg.in_div - 5'h01) begin
					in_cnt_r <= 5'h00;
					in_pulse_r <= 1'b1;
				end else begin
					in_cnt_r <= in_cnt_r + 5'h01;
				end
			end
		end
	end

	// Feedback prescaler counts pulses of the selected output divider.
	always_ff @(posedge clk) begin
		if (rst) begin
			fb_cnt_r <= pld_pkg::DIV_RESET;
			fb_pulse_r <= 1'b0;
		end else if (ce) begin
			fb_pulse_r <= 1'b0;
			if (fb_tick) begin
				if (fb_cnt_r == cfg.fb_div - 5'h01) begin
					fb_cnt_r <= 5'h00;
					fb_pulse_r <= 1'b1;
				end else begin
					fb_cnt_r <= fb_cnt_r + 5'h01;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Output dividers: code k gives ratio 2(k+1), halved in bypass and fed by the prescaler.
	assign fb_tick = dpulse[cfg.fb_sel > 3'h4 ? 3'h0 : cfg.fb_sel];
	// Gather the five ratio codes by field name so output k always reads its own code.
	assign out_codes = {cfg.out_div_4, cfg.out_div_3, cfg.out_div_2, cfg.out_div_1, cfg.out_div_0};
	generate
		for (genvar i = 0; i < pld_pkg::NUM_OUT; i++) begin : g_out
			logic [4:0] code;
			assign code = out_codes[i * 5 +: 5];
			assign ratio[i] = cfg.bypass ? {2'h0, code} + 7'h01 : {1'b0, code, 1'b0} + 7'h02;
			pld_divider u_div (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.tick(cfg.bypass ? in_pulse_r : vco_rise),
				.resync(resync_r),
				.ratio(ratio[i]),
				.out_r(dout[i]),
				.pulse_r(dpulse[i])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////////////
	// Phase detector: feedback pulse must land within a few cycles of the reference pulse.
	always_ff @(posedge clk) begin
		if (rst) begin
			fb_in_window_r <= 2'h0;
			phase_lock_r <= 1'b0;
		end else if (ce) begin
			fb_in_window_r <= {fb_in_window_r[0], fb_pulse_r};
			if (in_pulse_r) begin
				phase_lock_r <= fb_pulse_r | (|fb_in_window_r);
			end else if (ref_lost) begin
				phase_lock_r <= 1'b0;
			end
		end
	end

	// Reference-loss watchdog for the phase path.
	assign ref_lost = &ref_idle_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_idle_r <= 8'h00;
		end else if (ce) begin
			if (ref_rise) begin
				ref_idle_r <= 8'h00;
			end else if (!ref_lost) begin
				ref_idle_r <= ref_idle_r + 8'h01;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Frequency detector counts consecutive comparator cycles with exactly one feedback pulse.
	assign freq_target = ({5'h00, cfg.lock_cnt} + 9'h001) * 9'(pld_pkg::LOCK_STEP);
	logic fb_seen_r;
	logic fb_dup_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			fb_seen_r <= 1'b0;
			fb_dup_r <= 1'b0;
			freq_cnt_r <= 9'h000;
			freq_lock_r <= 1'b0;
		end else if (ce) begin
			if (in_pulse_r) begin
				fb_seen_r <= fb_pulse_r;
				fb_dup_r <= 1'b0;
				if (fb_seen_r && !fb_dup_r) begin
					if (freq_cnt_r < freq_target) begin
						freq_cnt_r <= freq_cnt_r + 9'h001;
					end
					freq_lock_r <= freq_lock_r | (freq_cnt_r + 9'h001 >= freq_target);
				end else begin
					freq_cnt_r <= 9'h000;
					freq_lock_r <= 1'b0;
				end
			end else if (fb_pulse_r) begin
				fb_dup_r <= fb_seen_r;
				fb_seen_r <= 1'b1;
			end
		end
	end

	// A new frequency lock resynchronises every output divider once.
	logic freq_lock_d_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			freq_lock_d_r <= 1'b0;
			resync_r <= 1'b0;
		end else if (ce) begin
			freq_lock_d_r <= freq_lock_r;
			resync_r <= freq_lock_r & ~freq_lock_d_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Lock output follows the selected detector outside bypass; frequency mode holds when reference stops.
	assign locked = (cfg.mode == pld_pkg::PLD_MODE_PHASE) ? phase_lock_r : freq_lock_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_n_r <= 1'b1;
		end else if (ce) begin
			lock_n_r <= cfg.bypass | ~locked;
		end
	end

	// Registered outputs and loop codes, clamped to the legal code range.
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_out_r <= 5'h00;
			cp_code_r <= pld_pkg::CP_RESET;
			res_code_r <= pld_pkg::RES_RESET;
			vco_base_r <= 5'h00;
		end else if (ce) begin
			clk_out_r <= dout;
			cp_code_r <= (cfg.cp_code > pld_pkg::CP_CODE_LAST) ? pld_pkg::CP_CODE_LAST : cfg.cp_code;
			res_code_r <= (cfg.res_code > pld_pkg::RES_CODE_LAST) ? pld_pkg::RES_CODE_LAST : cfg.res_code;
			vco_base_r <= vco_rise ? vco_base_r + 5'h01 : vco_base_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	a_lock_follows: assert property (@(posedge clk) disable iff (rst)
		ce && !cfg.bypass && cfg.mode == pld_pkg::PLD_MODE_FREQ && freq_lock_r |=> !lock_n_r)
		else $error("lock output not low while frequency locked");
	a_lock_drop: assert property (@(posedge clk) disable iff (rst)
		ce && !locked |=> lock_n_r)
		else $error("lock output not released on loss");
	a_resync_edge: assert property (@(posedge clk) disable iff (rst)
		ce && $rose(freq_lock_r) |=> resync_r)
		else $error("no resync on frequency lock");
	a_count_reset: assert property (@(posedge clk) disable iff (rst)
		ce && in_pulse_r && !(fb_seen_r && !fb_dup_r) |=> freq_cnt_r == 9'h000 && !freq_lock_r)
		else $error("frequency count not restarted");
	a_phase_loss: assert property (@(posedge clk) disable iff (rst)
		ce && ref_lost && !in_pulse_r |=> !phase_lock_r)
		else $error("phase lock held without reference");
	a_cp_range: assert property (@(posedge clk) disable iff (rst)
		cp_code_r <= pld_pkg::CP_CODE_LAST && res_code_r <= pld_pkg::RES_CODE_LAST)
		else $error("loop code out of range");
	a_freq_count: assert property (@(posedge clk) disable iff (rst)
		ce && $rose(freq_lock_r) |-> $past(freq_cnt_r) + 9'h001 >= freq_target)
		else $error("frequency lock too early");
	a_phase_set: assert property (@(posedge clk) disable iff (rst)
		ce && in_pulse_r && fb_pulse_r |=> phase_lock_r)
		else $error("phase lock not immediate");
endmodule : pld_core

//--- sim/pld_src_model.sv
// Source model for the reference clock and the oscillator stand-in.
// Assumes both pins are sampled by the core on the same 10 MHz clock.
`timescale 1ns/10ps
module pld_src_model #(
	parameter int VCO_HALF = 4
) (
	input wire logic clk,
	input wire logic ref_run,
	input int ref_half,
	input int vco_off,
	output logic ref_pin = 1'b0,
	output logic vco_pin = 1'b0
);
	int t_r = 0;
	int rt_r = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Free time base for the oscillator.
	always_ff @(posedge clk) begin
		t_r <= t_r + 1;
	end
	// Oscillator stand-in runs free with a shiftable phase.
	always_ff @(posedge clk) begin
		vco_pin <= (((t_r + vco_off) / VCO_HALF) % 2) == 1;
	end
	// Reference advances only while running, so a stopped reference stands still.
	always_ff @(posedge clk) begin
		if (ref_run) begin
			rt_r <= rt_r + 1;
			ref_pin <= ((rt_r / ref_half) % 2) == 1;
		end
	end
endmodule : pld_src_model

//--- sim/testbench.sv
// Self-checking bench for the divider and lock detect core.
// Assumes the source model drives the reference and oscillator pins.
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic ref_run = 1'b1;
	int ref_half = 8;
	int vco_off = 0;
	int error_cnt = 0;
	int num_checks = 0;
	pld_pkg::pld_cfg_t cfg;
	logic ref_pin, vco_pin, lock_n_r, freq_lock_r;
	logic [4:0] clk_out_r, vco_base_r;
	logic [3:0] cp_code_r;
	logic [2:0] res_code_r;
	////////////////////////////////////////////////////////////////////////////////
	// Clock with a 100 ns period.
	always #50 clk = ~clk;
	pld_src_model pld_src_model_i (.clk(clk), .ref_run(ref_run), .ref_half(ref_half), .vco_off(vco_off),
		.ref_pin(ref_pin), .vco_pin(vco_pin));
	pld_core pld_core_i (.clk(clk), .rst(rst), .ce(ce), .ref_pin(ref_pin), .vco_pin(vco_pin), .cfg(cfg),
		.lock_n_r(lock_n_r), .freq_lock_r(freq_lock_r), .clk_out_r(clk_out_r), .cp_code_r(cp_code_r),
		.res_code_r(res_code_r), .vco_base_r(vco_base_r));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	// Compares and counts.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	// Holds reset for twelve cycles and checks the levels inside it.
	task automatic do_reset();
		rst <= 1'b1;
		cyc(12);
		check(8'({lock_n_r, freq_lock_r, clk_out_r}), 8'h40);
		check({cp_code_r, 1'b0, res_code_r}, {pld_pkg::CP_RESET, 1'b0, pld_pkg::RES_RESET});
		rst <= 1'b0;
	endtask : do_reset
	// Waits a bounded time for the lock output to reach a level.
	task automatic wait_lock(input logic lvl, input int lim, output int w);
		w = 0;
		while (lock_n_r !== lvl && w < lim) begin
			@(posedge clk);
			w++;
		end
	endtask : wait_lock
	// Times frequency lock and notes a lock output that fell too early.
	task automatic meas_freq(output int w, output logic early);
		w = 0;
		early = 1'b0;
		while (freq_lock_r !== 1'b1 && w < 5000) begin
			@(posedge clk);
			w++;
			if (lock_n_r === 1'b0) early = 1'b1;
		end
	endtask : meas_freq
	// Counts rising edges of one output over 480 cycles, one edge of slack.
	task automatic edges(input int idx, input int exp);
		int n;
		logic p;
		n = 0;
		p = clk_out_r[idx];
		repeat (480) begin
			@(posedge clk);
			if (p === 1'b0 && clk_out_r[idx] === 1'b1) n++;
			p = clk_out_r[idx];
		end
		check(8'(n >= exp - 1 && n <= exp + 1), 8'h01);
	endtask : edges
	////////////////////////////////////////////////////////////////////////////////
	// Loop codes clamp to their last legal value.
	task automatic t_codes();
		logic [4:0] b;
		// The oscillator count must advance once per stand-in period of eight cycles.
		b = vco_base_r;
		cyc(80);
		check(8'(5'(vco_base_r - b)), 8'h0A);
		for (int i = 0; i < 16; i++) begin
			cfg.cp_code <= 4'(i);
			cfg.res_code <= 3'(i);
			cyc(3);
			check(8'(cp_code_r), 8'(i > 13 ? 13 : i));
			check(8'(res_code_r), 8'(i % 8 > 5 ? 5 : i % 8));
		end
		// With the clock enable low the clamped code must hold, then follow once enabled.
		ce <= 1'b0;
		cfg.cp_code <= 4'h3;
		cyc(3);
		check(8'(cp_code_r), 8'h0D);
		ce <= 1'b1;
		cyc(3);
		check(8'(cp_code_r), 8'h03);
	endtask : t_codes
	// Frequency lock needs (lock_cnt + 1) * 16 consecutive matching cycles.
	task automatic t_freq(input logic [3:0] k);
		int w;
		logic early;
		cfg.mode <= pld_pkg::PLD_MODE_FREQ;
		cfg.lock_cnt <= k;
		do_reset();
		meas_freq(w, early);
		check(8'(early), 8'h00);
		check(8'(w >= 256 * (k + 1) - 32 && w <= 256 * (k + 1) + 80), 8'h01);
		cyc(1);
		check(8'(lock_n_r), 8'h00);
	endtask : t_freq
	// Output ratios, then mismatch, relock from zero and a stopped reference.
	task automatic t_loss();
		int w;
		logic early;
		edges(0, 30);
		edges(2, 10);
		edges(3, 8);
		edges(4, 6);
		ref_half <= 12;
		wait_lock(1'b1, 100, w);
		check(8'(w < 100), 8'h01);
		ref_half <= 8;
		meas_freq(w, early);
		check(8'(w >= 224 && !early), 8'h01);
		cyc(2);
		ref_run <= 1'b0;
		cyc(400);
		check(8'(lock_n_r), 8'h00);
		ref_run <= 1'b1;
	endtask : t_loss
	// Phase lock over a sweep of oscillator phases, then loss of reference.
	task automatic t_phase();
		int w;
		cfg.mode <= pld_pkg::PLD_MODE_PHASE;
		w = 600;
		for (int off = 0; off < 16 && w >= 600; off++) begin
			vco_off <= off;
			do_reset();
			wait_lock(1'b0, 600, w);
		end
		check(8'(w < 600), 8'h01);
		cyc(pld_pkg::SETTLE_CYCLES + 100);
		check(8'(freq_lock_r), 8'h01);
		ref_run <= 1'b0;
		wait_lock(1'b1, 300, w);
		check(8'(w < 300), 8'h01);
		ref_run <= 1'b1;
	endtask : t_phase
	// Bypass feeds the prescaled reference to halved output ratios, no lock.
	task automatic t_bypass();
		cfg.mode <= pld_pkg::PLD_MODE_FREQ;
		cfg.bypass <= 1'b1;
		do_reset();
		cyc(400);
		check(8'(lock_n_r), 8'h01);
		edges(1, 15);
		cfg.bypass <= 1'b0;
	endtask : t_bypass
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence with a feedback product of 2, which takes the lowest loop settings.
	// No coarse skew is used, so the feedback product is not doubled for the loop choice.
	initial begin
		cfg = '{in_div: 5'h01, fb_div: 5'h01, out_div_0: 5'h00, out_div_1: 5'h01, out_div_2: 5'h02,
			out_div_3: 5'h03, out_div_4: 5'h04, fb_sel: 3'h0, bypass: 1'b0, mode: pld_pkg::PLD_MODE_FREQ,
			lock_cnt: 4'h0, cp_code: 4'h1, res_code: 3'h0};
		do_reset();
		t_codes();
		t_freq(4'hF);
		t_freq(4'h0);
		t_loss();
		t_phase();
		t_bypass();
		summarize();
	end
	// Cuts a hang short well past the expected run length.
	initial begin
		cyc(40000);
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		summarize();
	end
endmodule : testbench
